// >>> analog_ctl_cfg.svh
// Register offsets, field positions and reset values of the analog control block
`ifndef ANALOG_CTL_CFG_SVH
`define ANALOG_CTL_CFG_SVH
`define OFF_COP_SECURITY 16'h1ff0
`define OFF_ANALOG_STATUS 16'h001e
`define OFF_CHANNEL_SELECT 16'h0020
`define OFF_ANALOG_CONTROL 16'h0024
`define OFF_IRQ_STATUS 16'h0028
`define OFF_IRQ_MASK 16'h002c
`define OFF_POWER_MODE 16'h0030
`define BIT_OPTION_EN 0
`define BIT_VOFF 1
`define BIT_CMP1_PIN_EN 2
`define BIT_CMP1_OUT 3
`define BIT_CMP2_OUT 4
`define BIT_VREF 4
`define BIT_HOLD 5
`define BIT_DIV_HOLD 6
`define BIT_RAMP_EN 0
`define BIT_ATD_A 1
`define BIT_ATD_B 2
`define BIT_CHARGE_ON 3
`define BIT_DISCH 4
`define RST_BYTE 8'h00
`define IRQ_BITS 2
`endif

// >>> analog_ctl_pkg.sv
// Types shared by the analog control block
package analog_ctl_pkg;
  typedef struct packed {
    logic vrefSel;
    logic tempDiode;
    logic [3:0] pinSel;
    logic halveInput;
  } route_type;
  typedef struct packed {
    logic charge;
    logic discharge;
  } ramp_type;
  typedef enum logic [1:0] {
    MODE_RUN = 2'b00,
    MODE_WAIT = 2'b01,
    MODE_STOP = 2'b10
  } power_type;
endpackage

// >>> sticky_flag.sv
// One write-one-to-clear sticky status bit with edge detection
`timescale 1ns/1ps
`default_nettype none
module sticky_flag (
  input wire logic sys_clk,
  input wire logic rst_n,
  input wire logic level,
  input wire logic clearPulse,
  output logic flag
);
  logic levelDly;
  wire logic risePulse = level & ~levelDly;
  // Set wins over a clear in the same cycle so no event is lost
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      levelDly <= 1'b0;
      flag <= 1'b0;
    end else begin
      levelDly <= level;
      flag <= risePulse | (flag & ~clearPulse);
    end
  end
endmodule // sticky_flag

// >>> avalon_regs.sv
// Avalon-MM slave front end: one-cycle waitrequest then strobes
`timescale 1ns/1ps
`default_nettype none
module avalon_regs (
  input wire logic sys_clk,
  input wire logic rst_n,
  input wire logic read,
  input wire logic write,
  output logic waitrequest,
  output logic readStrobe,
  output logic writeStrobe
);
  logic served;
  // Every access waits one cycle; the second edge completes it
  assign waitrequest = (read | write) & ~served;
  assign readStrobe = read & served;
  assign writeStrobe = write & served;
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      served <= 1'b0;
    end else begin
      served <= (read | write) & ~served;
    end
  end
endmodule // avalon_regs

// >>> analog_mux_comparator_control.sv
// Analog channel routing, ramp source gating, comparator pin drive and wake-up control
`timescale 1ns/1ps
`default_nettype none
`include "analog_ctl_cfg.svh"
// Behaviour
// - Reference bit, no channels: route supply pin
// - Channel bit routes matching analog pin
// - Option and pin enable drive pin four OR
// - Option bit gates pin drive and offset
// - Source enable clear kills charge, discharge
// - Discharge may pull pin zero low
// - Charge current needs enable, mode zero, charge bit
// - Comparators wake processor from wait
// - Stop mode: no wake, pin drive only
// - Hold plus divided hold selects diode
// - Diode bias only while diode selected
module analog_mux_comparator_control (
  input wire logic sys_clk,
  input wire logic rst_n,
  input wire logic [15:0] address,
  input wire logic read,
  input wire logic write,
  input wire logic [31:0] writedata,
  output logic [31:0] readdata,
  output logic waitrequest,
  input wire logic cmp1Out,
  input wire logic cmp2Out,
  input wire logic portDataBit4,
  input wire logic timerOutputLevel,
  output logic pinFourOut,
  output analog_ctl_pkg::route_type route,
  output analog_ctl_pkg::ramp_type ramp,
  output logic diodeBiasOn,
  output logic sampleOffsetOn,
  output logic irq,
  output logic wakeRequest
);
  logic readStrobe;
  logic writeStrobe;
  logic [7:0] copSecurity;
  logic [7:0] analogStatus;
  logic [7:0] channelSelect;
  logic [7:0] analogControl;
  logic [1:0] irqMask;
  analog_ctl_pkg::power_type powerMode;
  logic [`IRQ_BITS-1:0] irqStatus;
  logic [7:0] next_readByte;

  avalon_regs busSlave (
    .sys_clk(sys_clk),
    .rst_n(rst_n),
    .read(read),
    .write(write),
    .waitrequest(waitrequest),
    .readStrobe(readStrobe),
    .writeStrobe(writeStrobe)
  );

  // Address decode
  wire logic hitCop = (address == `OFF_COP_SECURITY);
  wire logic hitStatus = (address == `OFF_ANALOG_STATUS);
  wire logic hitChannel = (address == `OFF_CHANNEL_SELECT);
  wire logic hitControl = (address == `OFF_ANALOG_CONTROL);
  wire logic hitIrqStat = (address == `OFF_IRQ_STATUS);
  wire logic hitIrqMask = (address == `OFF_IRQ_MASK);
  wire logic hitPower = (address == `OFF_POWER_MODE);
  wire logic [1:0] clearBits = (writeStrobe & hitIrqStat) ? writedata[1:0] : 2'h0;

  // Register writes; unmapped writes are ignored and unmapped reads return zero
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      copSecurity <= `RST_BYTE;
      analogStatus <= `RST_BYTE;
      channelSelect <= `RST_BYTE;
      analogControl <= `RST_BYTE;
      irqMask <= 2'h0;
      powerMode <= analog_ctl_pkg::MODE_RUN;
    end else if (writeStrobe) begin
      if (hitCop) copSecurity <= writedata[7:0];
      else if (hitStatus) analogStatus <= writedata[7:0];
      else if (hitChannel) channelSelect <= writedata[7:0];
      else if (hitControl) analogControl <= writedata[7:0];
      else if (hitIrqMask) irqMask <= writedata[1:0];
      else if (hitPower) powerMode <= analog_ctl_pkg::power_type'(writedata[1:0]);
    end
  end

  // Comparator event flags, one per comparator
  sticky_flag cmp1Flag (
    .sys_clk(sys_clk),
    .rst_n(rst_n),
    .level(cmp1Out),
    .clearPulse(clearBits[0]),
    .flag(irqStatus[0])
  );
  sticky_flag cmp2Flag (
    .sys_clk(sys_clk),
    .rst_n(rst_n),
    .level(cmp2Out),
    .clearPulse(clearBits[1]),
    .flag(irqStatus[1])
  );

  // Option and enable bits
  wire logic optOn = copSecurity[`BIT_OPTION_EN];
  wire logic cmp1PinEnable = analogStatus[`BIT_CMP1_PIN_EN];
  wire logic rampEnable = analogControl[`BIT_RAMP_EN];
  wire logic atdA = analogControl[`BIT_ATD_A];
  wire logic atdB = analogControl[`BIT_ATD_B];
  wire logic chargeOn = analogControl[`BIT_CHARGE_ON];
  wire logic dischReq = analogControl[`BIT_DISCH];
  wire logic hold = channelSelect[`BIT_HOLD];
  wire logic dividedHold = channelSelect[`BIT_DIV_HOLD];
  wire logic diodeSel = hold & dividedHold;
  wire logic manualCharge = rampEnable & ~atdA & ~atdB & chargeOn;
  wire logic irqAny = |(irqStatus & irqMask);
  wire logic inStop = (powerMode == analog_ctl_pkg::MODE_STOP);

  // Comparator drive only reaches pin four when both option and enable are set
  wire logic cmpToPin = optOn & cmp1PinEnable & cmp1Out;

  // Pin four still works in stop mode so external wiring can wake the part
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      pinFourOut <= 1'b0;
    end else begin
      pinFourOut <= cmpToPin | portDataBit4 | timerOutputLevel;
    end
  end

  // Routing outputs registered to keep switching glitch free
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      route <= '0;
      ramp <= '0;
      diodeBiasOn <= 1'b0;
      sampleOffsetOn <= 1'b0;
    end else begin
      route.vrefSel <= channelSelect[`BIT_VREF] & (channelSelect[3:0] == 4'h0);
      route.pinSel <= channelSelect[3:0];
      route.tempDiode <= diodeSel;
      route.halveInput <= dividedHold & ~hold;
      diodeBiasOn <= diodeSel;
      sampleOffsetOn <= optOn & analogStatus[`BIT_VOFF];
      ramp.charge <= manualCharge;
      ramp.discharge <= rampEnable & dischReq & ~manualCharge;
    end
  end

  // Interrupt level; wake only outside stop, the pin covers stop
  assign irq = irqAny;
  assign wakeRequest = irqAny & ~inStop;

  // Read mux, combinational; gated onto readdata at the completing edge
  always_comb begin
    next_readByte = 8'h00;
    if (hitCop) next_readByte = copSecurity;
    else if (hitStatus) begin
      next_readByte = analogStatus;
      next_readByte[`BIT_CMP1_OUT] = cmp1Out;
      next_readByte[`BIT_CMP2_OUT] = cmp2Out;
    end
    else if (hitChannel) next_readByte = channelSelect;
    else if (hitControl) next_readByte = analogControl;
    else if (hitIrqStat) next_readByte = {6'h00, irqStatus};
    else if (hitIrqMask) next_readByte = {6'h00, irqMask};
    else if (hitPower) next_readByte = {6'h00, powerMode};
  end

  // Read data presented combinationally off registered state and the live cmp1Out/cmp2Out inputs when waitrequest drops
  assign readdata = readStrobe ? {24'h000000, next_readByte} : 32'h00000000;
endmodule // analog_mux_comparator_control
`default_nettype wire

// >>> analog_ctl_asserts.sv
// Port-level assertions for the analog control block
`timescale 1ns/1ps
`default_nettype none
module analog_ctl_asserts (
  input wire logic sys_clk,
  input wire logic rst_n,
  input wire logic read,
  input wire logic write,
  input wire logic [31:0] readdata,
  input wire logic waitrequest,
  input wire logic portDataBit4,
  input wire logic timerOutputLevel,
  input wire logic pinFourOut,
  input wire analog_ctl_pkg::route_type route,
  input wire analog_ctl_pkg::ramp_type ramp,
  input wire logic diodeBiasOn,
  input wire logic irq,
  input wire logic wakeRequest
);
  default clocking @(posedge sys_clk); endclocking
  default disable iff (!rst_n);
  // An access waits one cycle, then is answered
  sequence s_req; (read || write) && waitrequest; endsequence
  sequence s_ans; !waitrequest; endsequence
  property p_bus; s_req |=> s_ans; endproperty
  a_bus: assert property (p_bus) else $error("access not answered");
  property p_first; $rose(read || write) |-> waitrequest; endproperty
  a_first: assert property (p_first) else $error("no wait cycle");
  property p_rdzero; !(read && !waitrequest) |-> readdata == 32'h0; endproperty
  a_rdzero: assert property (p_rdzero) else $error("stray read data");
  property p_pin4; (portDataBit4 || timerOutputLevel) |=> pinFourOut; endproperty
  a_pin4: assert property (p_pin4) else $error("pin four OR lost");
  property p_bias; diodeBiasOn == route.tempDiode; endproperty
  a_bias: assert property (p_bias) else $error("diode bias mismatch");
  property p_ramp; ramp.charge |-> !ramp.discharge; endproperty
  a_ramp: assert property (p_ramp) else $error("charge with discharge");
  property p_vref; route.vrefSel |-> route.pinSel == 4'h0; endproperty
  a_vref: assert property (p_vref) else $error("supply with a pin");
  property p_sel; $onehot0(route.pinSel); endproperty
  a_sel: assert property (p_sel) else $error("two pins routed");
  property p_wake; wakeRequest |-> irq; endproperty
  a_wake: assert property (p_wake) else $error("wake without irq");
endmodule // analog_ctl_asserts
bind analog_mux_comparator_control analog_ctl_asserts analog_ctl_asserts_i (.*);
`default_nettype wire

// >>> analog_partner.sv
// Comparator and port-level model beside the block
`timescale 1ns/1ps
`default_nettype none
module analog_partner (
  input wire logic sys_clk,
  input wire logic [3:0] level,
  output logic cmp1Out,
  output logic cmp2Out,
  output logic portDataBit4,
  output logic timerOutputLevel
);
  // Comparator pins are inputs with pulldowns off, so levels pass unloaded
  // No capture interrupt is modelled: software keeps it off while comparing
  // Levels lag a clock, like a slow analog stage
  always_ff @(posedge sys_clk) begin
    {timerOutputLevel, portDataBit4, cmp2Out, cmp1Out} <= level;
  end
endmodule // analog_partner
`default_nettype wire

// >>> testbench.sv
// Self-checking bench of the analog control block
`timescale 1ns/1ps
`default_nettype none
module testbench;
  logic sys_clk, rst_n, read, write, waitrequest, cmp1Out, cmp2Out, portDataBit4;
  logic timerOutputLevel, pinFourOut, diodeBiasOn, sampleOffsetOn, irq, wakeRequest;
  logic [15:0] address;
  logic [31:0] writedata, readdata, q;
  logic [31:0] rng = 32'h6;
  logic [3:0] level;
  analog_ctl_pkg::route_type route;
  analog_ctl_pkg::ramp_type ramp;
  int errorCnt = 0;
  int checked = 0;
  analog_mux_comparator_control analog_mux_comparator_control_i (.*);
  analog_partner analog_partner_i (.*);
  initial begin
    sys_clk = 0;
    forever #5 sys_clk = ~sys_clk;
  end
  function automatic logic [31:0] xs(input logic [31:0] s);
    xs = s ^ (s << 13);
    xs = xs ^ (xs >> 17);
    xs = xs ^ (xs << 5);
  endfunction
  // Pin four is the OR; comparator 1 counts only when enabled
  function automatic logic expPin(input logic [3:0] l, input logic en);
    expPin = (l[0] & en) | l[2] | l[3];
  endfunction
  // Hold the request until waitrequest is seen low at a rising edge
  task automatic bus(input logic wr, input logic [15:0] a, input logic [7:0] d);
    int n = 0;
    @(posedge sys_clk);
    address <= a;
    writedata <= {24'h0, d};
    write <= wr;
    read <= !wr;
    do begin
      @(posedge sys_clk);
      n++;
    end while (waitrequest !== 1'b0 && n < 20);
    // Read data is taken at the very edge that sees waitrequest low
    q = readdata;
    read <= 0;
    write <= 0;
    if (n >= 20) errorCnt++;
  endtask
  // Outputs lag a write by a cycle
  task automatic wr(input logic [15:0] a, input logic [7:0] d);
    bus(1, a, d);
    repeat (2) @(posedge sys_clk);
    @(negedge sys_clk);
  endtask
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    checked++;
    if (g !== e) begin
      $display("CHECK FAILED %s expected %h seen %h", nm, e, g);
      errorCnt++;
    end
  endtask
  task automatic conclude;
    $display("checks %0d mismatches %0d", checked, errorCnt);
    if (errorCnt == 0 && checked > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask
  initial begin
    #200000;
    errorCnt++;
    conclude;
  end
  initial begin
    rst_n = 0; read = 0; write = 0; address = 16'h0; writedata = 32'h0; level = 4'h0;
    repeat (2) @(posedge sys_clk);
    rst_n <= 1;
    bus(0, 16'h0020, 8'h0); chk("chanReset", 32'h0, q);
    bus(0, 16'h0040, 8'h0); chk("unmapped", 32'h0, q);
    for (int i = 0; i < 4; i++) begin
      wr(16'h0020, 8'h01 << i); chk("pinSel", 32'h1 << i, route.pinSel);
    end
    wr(16'h0020, 8'h50); chk("vref", 32'h3, {route.vrefSel, route.halveInput});
    wr(16'h0020, 8'h60); chk("diode", 32'h3, {route.tempDiode, diodeBiasOn});
    wr(16'h0020, 8'h20); chk("diodeOff", 32'h0, {route.tempDiode, diodeBiasOn});
    wr(16'h0024, 8'h09); chk("charge", 32'h2, ramp);
    wr(16'h0024, 8'h0b); chk("chargeMode", 32'h0, ramp);
    wr(16'h0024, 8'h11); chk("discharge", 32'h1, ramp);
    wr(16'h0024, 8'h18); chk("rampOff", 32'h0, ramp);
    $display("test routing and ramp done");
    @(posedge sys_clk) level <= 4'h1;
    wr(16'h1ff0, 8'h01);
    wr(16'h001e, 8'h06); chk("pin4", 32'h1, pinFourOut);
    chk("offset", 32'h1, sampleOffsetOn);
    bus(0, 16'h001e, 8'h0); chk("status", 32'h0e, q);
    wr(16'h1ff0, 8'h00); chk("pin4Off", 32'h0, {pinFourOut, sampleOffsetOn});
    // Random levels with the option bit toggled at random
    for (int i = 0; i < 16; i++) begin
      rng = xs(rng);
      @(posedge sys_clk) level <= rng[3:0];
      wr(16'h1ff0, {7'h0, rng[4]}); chk("pin4Rnd", expPin(rng[3:0], rng[4]), pinFourOut);
    end
    $display("test pin four done");
    @(posedge sys_clk) level <= 4'h0;
    wr(16'h0028, 8'h03);
    wr(16'h002c, 8'h00);
    @(posedge sys_clk) level <= 4'h1;
    wr(16'h0030, 8'h01); chk("masked", 32'h0, {irq, wakeRequest});
    bus(0, 16'h0028, 8'h0); chk("sticky", 32'h1, q);
    wr(16'h002c, 8'h01); chk("wait", 32'h3, {irq, wakeRequest});
    wr(16'h0030, 8'h02); chk("stop", 32'h2, {irq, wakeRequest});
    wr(16'h0028, 8'h01); chk("cleared", 32'h0, irq);
    $display("test interrupts done");
    conclude;
  end
endmodule // testbench
`default_nettype wire
